// ==== hw/dci_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dci_top
  import dci_pkg::*;
#(
  parameter int   NUM_PORTS  = 2,
  parameter int   FIFO_DEPTH = 4,
  parameter logic INT_EN_LVL = 1'b0
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       req_valid,
  input  wire dci_req_s   req,
  output logic            req_ready,
  output logic            resp_valid,
  output dci_resp_s       resp,
  input  wire logic       scan_valid,
  input  wire dci_scan_s  scan,
  output logic            scan_ready,
  input  wire logic       out_port,
  input  wire logic [5:0] out_slave,
  output logic [31:0]     out_word,
  input  wire logic       int_ack,
  output logic            irq,
  output logic            scan_pause
);

  ////////////////////////////////////////////////////////////////////
  // Per-slave state, indexed by {port, slave}, then the global control and output registers.

  logic [31:0] in_mem_r  [IDX_N];
  logic [31:0] out_mem_r [IDX_N];
  logic [15:0] mask_r    [IDX_N];
  logic [15:0] chg_r     [IDX_N];
  logic        ilog_r    [IDX_N];
  logic        olog_r    [IDX_N];
  logic        wide_r    [IDX_N];

  logic [1:0]  type_r;
  logic        ctrl_r;
  logic        seen_r;
  logic        irq_r;
  logic        pause_r;
  logic        req_ready_r;
  logic        resp_valid_r;
  dci_resp_s   resp_r;
  logic [31:0] out_word_r;

  ////////////////////////////////////////////////////////////////////
  // Scan data buffer between the link engine and the image.

  logic      fifo_in_ready;
  logic      fifo_valid;
  logic      fifo_ready;
  dci_scan_s fifo_data;
  logic      pop;

  // Draining stops while paused, so a halted scan backs up the link.
  assign fifo_ready = !pause_r;

  dci_fifo #(
    .W     ($bits(dci_scan_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (scan_valid),
    .in_data   (scan),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_ready)
  );

  assign pop = fifo_valid && fifo_ready;

  ////////////////////////////////////////////////////////////////////
  // Request decode and checks.

  logic       take;
  logic       bulk;
  logic [5:0] slv_c;
  logic [6:0] idx_c;
  logic       port_bad;
  logic       slv_bad;
  logic       chan_bad;
  logic       type_bad;
  logic       need_slv;
  logic       need_ch;
  dci_err_e   err_c;

  assign take = req_valid && req_ready_r;
  assign bulk = (req.op == OP_RD_ALL_IN) || (req.op == OP_WR_ALL_OUT);

  // Bulk entry k belongs to slave k plus one.
  assign slv_c = bulk ? req.slave + 6'h01 : req.slave;
  assign idx_c = {req.port[0], slv_c};

  assign need_slv = !(req.op == OP_SET_TYPE || req.op == OP_SET_CTRL);
  assign need_ch  = (req.op == OP_RD_CH_IN) || (req.op == OP_WR_CH_OUT);

  // Ports beyond the ones fitted are refused.
  assign port_bad = (32'(req.port) >= NUM_PORTS);

  // Bulk entries run 0 to 62; plain slaves run 1 to 63.
  assign slv_bad = need_slv &&
                   (bulk ? (req.slave > BULK_LAST)
                         : (req.slave < SLV_MIN));

  // Narrow modules only have channels 0 to 15.
  assign chan_bad = need_ch && !wide_r[idx_c] &&
                    (req.chan > CH_NAR_MAX);

  assign type_bad = (req.op == OP_SET_TYPE) &&
                    ((req.data[31:2] != '0) ||
                     (req.data[1:0] == 2'h0));

  // Port first, then slave, then channel, then type.
  always_comb begin
    err_c = ERR_NONE;
    if (port_bad) begin
      err_c = ERR_PORT;
    end else if (slv_bad) begin
      err_c = ERR_SLAVE;
    end else if (chan_bad) begin
      err_c = ERR_CHAN;
    end else if (type_bad) begin
      err_c = ERR_TYPE;
    end
  end

  logic ok;
  assign ok = take && (err_c == ERR_NONE);

  ////////////////////////////////////////////////////////////////////
  // Channel helpers for single-bit access.

  logic [31:0] out_ins;
  logic        in_bit;
  logic [31:0] in_log;

  // Input logic is applied on the way out to the host.
  assign in_log = in_mem_r[idx_c] ^ {32{ilog_r[idx_c]}};

  dci_bit u_wr_bit (
    .word     (out_mem_r[idx_c]),
    .chan     (req.chan),
    .bit_in   (req.data[0]),
    .word_ins (out_ins),
    .bit_out  ()
  );

  dci_bit u_rd_bit (
    .word     (in_log),
    .chan     (req.chan),
    .bit_in   (1'b0),
    .word_ins (),
    .bit_out  (in_bit)
  );

  ////////////////////////////////////////////////////////////////////
  // Answer path: one answer the cycle after each request is taken.

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      req_ready_r  <= 1'b0;
      resp_valid_r <= 1'b0;
      resp_r       <= '{err: ERR_NONE, data: WORD_RST};
    end else begin
      req_ready_r  <= 1'b1;
      resp_valid_r <= take;
      if (take) begin
        resp_r.err  <= err_c;
        resp_r.data <= WORD_RST;
        if (err_c == ERR_NONE) begin
          unique case (req.op)
            OP_RD_IN:     resp_r.data <= in_log;
            OP_RD_CH_IN:  resp_r.data <= {31'h0, in_bit};
            OP_RD_OUT:    resp_r.data <= out_mem_r[idx_c];
            OP_RD_ALL_IN: resp_r.data <= {16'h0, in_log[15:0]};
            OP_RD_CHG:    resp_r.data <= {16'h0, chg_r[idx_c]};
            default:      resp_r.data <= WORD_RST;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output image: host writes, link engine fetches.

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < IDX_N; i++) begin
        out_mem_r[i] <= WORD_RST;
      end
    end else if (ok) begin
      unique case (req.op)
        OP_WR_OUT:     out_mem_r[idx_c] <= req.data;
        OP_WR_CH_OUT:  out_mem_r[idx_c] <= out_ins;
        OP_WR_ALL_OUT: out_mem_r[idx_c][15:0] <= req.data[15:0];
        default:       ;
      endcase
    end
  end

  // The stored word stays as written; only the copy sent out is
  // inverted, so read-back never depends on the logic setting.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_word_r <= WORD_RST;
    end else begin
      out_word_r <= out_mem_r[{out_port, out_slave}] ^
                    {32{olog_r[{out_port, out_slave}]}};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Per-slave settings.

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < IDX_N; i++) begin
        mask_r[i] <= MASK_RST;
        ilog_r[i] <= LOGIC_RST;
        olog_r[i] <= LOGIC_RST;
        wide_r[i] <= WIDE_RST;
      end
    end else if (ok) begin
      unique case (req.op)
        OP_SET_IN_LOGIC:  ilog_r[idx_c] <= req.data[0];
        OP_SET_OUT_LOGIC: olog_r[idx_c] <= req.data[0];
        OP_SET_MASK:      mask_r[idx_c] <= req.data[15:0];
        OP_SET_WIDE:      wide_r[idx_c] <= req.data[0];
        default:          ;
      endcase
    end
  end

  // Global controls; a refused type leaves the old one in place.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      type_r <= TYPE_RST;
      ctrl_r <= !INT_EN_LVL;
    end else if (ok) begin
      if (req.op == OP_SET_TYPE) type_r <= req.data[1:0];
      if (req.op == OP_SET_CTRL) ctrl_r <= req.data[0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Scan intake and transition detection.

  logic [6:0]  sidx;
  logic [15:0] diff;
  logic        s_ok;
  logic        chg_any;
  logic        en;

  assign sidx = {fifo_data.port, fifo_data.slave};
  // Entries for slave zero cannot be real and are dropped.
  assign s_ok = pop && (fifo_data.slave >= SLV_MIN);

  // Compare against the previous scan under the monitor mask.
  assign diff = (in_mem_r[sidx][15:0] ^ fifo_data.word[15:0]) &
                mask_r[sidx];
  assign chg_any = s_ok && (diff != 16'h0);
  assign en = (ctrl_r == INT_EN_LVL);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < IDX_N; i++) begin
        in_mem_r[i] <= WORD_RST;
      end
    end else if (s_ok) begin
      in_mem_r[sidx] <= fifo_data.word;
    end
  end

  // Changed bits latch until acknowledged; a new change wins over
  // an acknowledge that lands in the same cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < IDX_N; i++) begin
        chg_r[i] <= 16'h0;
      end
    end else begin
      for (int i = 0; i < IDX_N; i++) begin
        if (chg_any && sidx == 7'(i)) begin
          chg_r[i] <= (int_ack ? 16'h0 : chg_r[i]) | diff;
        end else if (int_ack) begin
          chg_r[i] <= 16'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt timing.

  logic fire;
  logic scan_end;

  assign scan_end = pop && fifo_data.last;

  always_comb begin
    fire = 1'b0;
    if (en) begin
      unique case (type_r)
        TYPE_IMM:  fire = chg_any;
        TYPE_END:  fire = scan_end && (seen_r || chg_any);
        TYPE_HALT: fire = scan_end && (seen_r || chg_any);
        default:   fire = 1'b0;
      endcase
    end
  end

  // Remembers a change seen earlier in the current scan cycle; nothing
  // is remembered while disabled, so enabling never fires on old news.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seen_r <= 1'b0;
    end else if (scan_end || !en) begin
      seen_r <= 1'b0;
    end else if (chg_any) begin
      seen_r <= 1'b1;
    end
  end

  // Set beats acknowledge so a change at the clear is not lost.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else if (fire) begin
      irq_r <= 1'b1;
    end else if (int_ack) begin
      irq_r <= 1'b0;
    end
  end

  // Pause holds until the host clears it; the scan period is then
  // no longer constant, which the user must accept with this type.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pause_r <= 1'b0;
    end else if (fire && type_r == TYPE_HALT) begin
      pause_r <= 1'b1;
    end else if (int_ack || !en) begin
      pause_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs.

  assign req_ready  = req_ready_r;
  assign resp_valid = resp_valid_r;
  assign resp       = resp_r;
  assign out_word   = out_word_r;
  assign irq        = irq_r;
  assign scan_pause = pause_r;
  assign scan_ready = fifo_in_ready;

endmodule : dci_top
`default_nettype wire

// ==== inc/dci_pkg.sv ====
// Overview of operation
// - Channel n of a slave maps to bit n of its 32-bit word.
// - Only slave indexes 1 to 63 are accepted; others give slave error.
// - Bulk images hold 63 sixteen-bit entries; entry k is slave k+1.
// - Channels 0 to 15 on narrow modules, 0 to 31 on wide modules.
// - Single-channel output write changes only the addressed output bit.
// - Single-channel input read returns one bit of latest scanned word.
// - Last written output word is kept locally and read back from it.
// - Per-slave input and output logic settings apply to their data.
// - Timing type accepts 1 to 3 only; others refused, type kept.
// - Type 1 raises the interrupt as soon as a transition is seen.
// - Type 2 raises it after a transition once the scan cycle ends.
// - Type 3 acts as type 2, then pauses scanning until host clears.
// - Per-slave 16-bit change monitor mask selects the checked bits.
// - Enable control polarity is uncertain; it is a parameter here.
// - Port 0 only on one-port master, 0 or 1 on two-port master.
package dci_pkg;

  localparam int          SLV_W       = 6;
  localparam int          IDX_N       = 128;
  localparam logic [5:0]  SLV_MIN     = 6'h01;
  localparam logic [5:0]  SLV_MAX     = 6'h3f;
  localparam logic [5:0]  BULK_LAST   = 6'h3e;
  localparam logic [4:0]  CH_NAR_MAX  = 5'h0f;
  localparam logic [1:0]  TYPE_IMM    = 2'h1;
  localparam logic [1:0]  TYPE_END    = 2'h2;
  localparam logic [1:0]  TYPE_HALT   = 2'h3;
  localparam logic [1:0]  TYPE_RST    = 2'h1;
  localparam logic [15:0] MASK_RST    = 16'h0000;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic        WIDE_RST    = 1'b1;
  localparam logic        LOGIC_RST   = 1'b0;

  typedef enum logic [3:0] {
    OP_RD_IN, OP_RD_CH_IN, OP_WR_OUT, OP_WR_CH_OUT, OP_RD_OUT,
    OP_RD_ALL_IN, OP_WR_ALL_OUT, OP_SET_IN_LOGIC, OP_SET_OUT_LOGIC,
    OP_SET_TYPE, OP_SET_MASK, OP_SET_CTRL, OP_SET_WIDE, OP_RD_CHG
  } dci_op_e;

  typedef enum logic [2:0] {
    ERR_NONE, ERR_PORT, ERR_SLAVE, ERR_CHAN, ERR_TYPE
  } dci_err_e;

  typedef struct packed {
    dci_op_e     op;
    logic [1:0]  port;
    logic [5:0]  slave;
    logic [4:0]  chan;
    logic [31:0] data;
  } dci_req_s;

  typedef struct packed {
    dci_err_e    err;
    logic [31:0] data;
  } dci_resp_s;

  typedef struct packed {
    logic        port;
    logic [5:0]  slave;
    logic [31:0] word;
    logic        last;
  } dci_scan_s;

endpackage : dci_pkg

// ==== hw/dci_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module dci_fifo #(
  parameter int W     = 40,
  parameter int DEPTH = 4
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // Flags come straight from the count so full and empty stay honest.
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  // Storage is written only on push; no reset needed for data.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // Pointers wrap at the depth, which must be a power of two.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop)  rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dci_fifo
`default_nettype wire

// ==== hw/dci_bit.sv ====
`timescale 1ns/1ps
`default_nettype none
module dci_bit (
  input  wire logic [31:0] word,
  input  wire logic [4:0]  chan,
  input  wire logic        bit_in,
  output logic [31:0]      word_ins,
  output logic             bit_out
);
  // Channel n is bit n of the word, channel zero in bit zero.
  always_comb begin
    word_ins       = word;
    word_ins[chan] = bit_in;
    bit_out        = word[chan];
  end
endmodule : dci_bit
`default_nettype wire

// ==== bench/dci_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module dci_top_assertions
  import dci_pkg::*;
#(
  parameter int   NUM_PORTS  = 2,
  parameter int   FIFO_DEPTH = 4,
  parameter logic INT_EN_LVL = 1'b0
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       req_valid,
  input wire dci_req_s   req,
  input wire logic       req_ready,
  input wire logic       resp_valid,
  input wire dci_resp_s  resp,
  input wire logic       scan_valid,
  input wire dci_scan_s  scan,
  input wire logic       scan_ready,
  input wire logic       int_ack,
  input wire logic       irq,
  input wire logic       scan_pause
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Request qualifiers shared by the error checks below.
  logic tk;
  logic pok;
  logic bulk;
  assign tk   = req_valid && req_ready;
  assign pok  = req.port < NUM_PORTS;
  assign bulk = req.op inside {OP_RD_ALL_IN, OP_WR_ALL_OUT};
  ////////////////////////////////////////////////////////////////////////////
  chk_resp_pulse: assert property (resp_valid == $past(tk))
    else $error("answer pulse mismatch");
  chk_port_refused: assert property (tk && !pok |=> resp.err == ERR_PORT)
    else $error("bad port accepted");
  chk_slave_zero: assert property (tk && pok && !bulk && req.slave == 6'h00
    && !(req.op inside {OP_SET_TYPE, OP_SET_CTRL}) |=> resp.err == ERR_SLAVE)
    else $error("slave zero accepted");
  chk_bulk_range: assert property (tk && pok && bulk
    && req.slave > BULK_LAST |=> resp.err == ERR_SLAVE)
    else $error("bulk entry past end accepted");
  chk_type_refused: assert property (tk && pok && req.op == OP_SET_TYPE
    && !(req.data inside {[1:3]}) |=> resp.err == ERR_TYPE)
    else $error("bad timing type accepted");
  chk_irq_sticky: assert property (irq && !int_ack |=> irq)
    else $error("irq dropped without ack");
  chk_ack_clears: assert property (scan_pause && int_ack |=> !scan_pause && !irq)
    else $error("ack did not resume");
  chk_pause_irq: assert property (scan_pause |-> irq)
    else $error("pause without irq");
  // A pause may only end by ack or by a control change.
  chk_pause_holds: assert property (scan_pause && !int_ack
    && !(tk && req.op inside {OP_SET_CTRL, OP_SET_TYPE})
    && !$past(tk && req.op == OP_SET_CTRL) |=> scan_pause)
    else $error("pause ended early");
  cover property ($rose(irq));
  cover property ($rose(scan_pause));
  cover property (scan_valid && !scan_ready);
  cover property (resp_valid && resp.err == ERR_TYPE);
endmodule : dci_top_assertions
bind dci_top dci_top_assertions #(.NUM_PORTS(NUM_PORTS),
  .FIFO_DEPTH(FIFO_DEPTH), .INT_EN_LVL(INT_EN_LVL)) i_chk (.clk(clk),
  .resetn(resetn), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .resp_valid(resp_valid), .resp(resp), .scan_valid(scan_valid),
  .scan(scan), .scan_ready(scan_ready), .int_ack(int_ack), .irq(irq),
  .scan_pause(scan_pause));
`default_nettype wire

// ==== bench/dci_slave_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dci_slave_model
  import dci_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic slow,
  input  wire logic scan_ready,
  output logic      scan_valid,
  output dci_scan_s scan,
  output logic      idle
);
  dci_scan_s q[$];
  // Only words of slaves 1 to 63 on port 0 are queued by the bench.
  task automatic push(dci_scan_s s);
    q.push_back(s);
  endtask : push
  assign idle = (q.size() == 0) && !scan_valid;
  // Offers held until taken; a released word is inverted so stale data
  // never looks valid. Slow mode leaves a gap after every word.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scan_valid <= 1'b0;
      scan       <= '0;
    end else if (!scan_valid || scan_ready) begin
      if (q.size() > 0 && !(slow && scan_valid)) begin
        scan       <= q.pop_front();
        scan_valid <= 1'b1;
      end else begin
        scan_valid <= 1'b0;
        scan.word  <= ~scan.word;
      end
    end
  end
endmodule : dci_slave_model
`default_nettype wire

// ==== bench/tb_dci_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_dci_top import dci_pkg::*;;
  typedef struct {dci_op_e o; logic [1:0] p; logic [5:0] s; logic [4:0] c;
    logic [31:0] d; dci_err_e e; logic [31:0] r;} dci_row_s;
  logic clk = 1'b0, resetn, req_valid, req_ready, resp_valid, scan_valid;
  logic scan_ready, out_port, int_ack, irq, scan_pause, slow, slv_idle;
  logic [5:0] out_slave;
  logic [31:0] out_word;
  dci_req_s req;
  dci_resp_s resp;
  dci_scan_s scan;
  int fails = 0, n_checks = 0;
  // Each row: request, then the error and read data it must answer with.
  dci_row_s rows [22] = '{
    '{OP_WR_OUT, 0, 5, 0, 32'h8000_0001, ERR_NONE, 0},
    '{OP_RD_OUT, 0, 5, 0, 0, ERR_NONE, 32'h8000_0001},
    '{OP_WR_CH_OUT, 0, 5, 4, 1, ERR_NONE, 0},
    '{OP_WR_CH_OUT, 0, 5, 31, 0, ERR_NONE, 0},
    '{OP_RD_OUT, 0, 5, 0, 0, ERR_NONE, 32'h11},
    '{OP_WR_OUT, 2, 5, 0, 1, ERR_PORT, 0},
    '{OP_SET_TYPE, 3, 0, 0, 0, ERR_PORT, 0},
    '{OP_WR_OUT, 0, 0, 0, 1, ERR_SLAVE, 0},
    '{OP_WR_ALL_OUT, 0, 62, 0, 32'h1234, ERR_NONE, 0},
    '{OP_RD_OUT, 0, 63, 0, 0, ERR_NONE, 32'h1234},
    '{OP_RD_ALL_IN, 0, 63, 0, 0, ERR_SLAVE, 0},
    '{OP_SET_WIDE, 0, 7, 0, 0, ERR_NONE, 0},
    '{OP_WR_CH_OUT, 0, 7, 16, 1, ERR_CHAN, 0},
    '{OP_WR_CH_OUT, 0, 7, 15, 1, ERR_NONE, 0},
    '{OP_RD_OUT, 0, 7, 0, 0, ERR_NONE, 32'h8000},
    '{OP_SET_TYPE, 0, 0, 0, 4, ERR_TYPE, 0},
    '{OP_RD_IN, 0, 3, 0, 0, ERR_NONE, 32'ha5},
    '{OP_RD_CH_IN, 0, 3, 2, 0, ERR_NONE, 1},
    '{OP_RD_ALL_IN, 0, 2, 0, 0, ERR_NONE, 32'ha5},
    '{OP_SET_IN_LOGIC, 0, 3, 0, 1, ERR_NONE, 0},
    '{OP_RD_IN, 0, 3, 0, 0, ERR_NONE, 32'hffff_ff5a},
    '{OP_SET_OUT_LOGIC, 0, 5, 0, 1, ERR_NONE, 0}};
  dci_top i_dut (.clk(clk), .resetn(resetn), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .resp_valid(resp_valid), .resp(resp),
    .scan_valid(scan_valid), .scan(scan), .scan_ready(scan_ready),
    .out_port(out_port), .out_slave(out_slave), .out_word(out_word),
    .int_ack(int_ack), .irq(irq), .scan_pause(scan_pause));
  dci_slave_model i_slv (.clk(clk), .resetn(resetn), .slow(slow),
    .scan_ready(scan_ready), .scan_valid(scan_valid), .scan(scan),
    .idle(slv_idle));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(logic [31:0] s, logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Request held until taken; the answer is looked at in its one cycle.
  task automatic rq(dci_op_e o, logic [1:0] p, logic [5:0] s,
                    logic [4:0] c, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{o, p, s, c, d};
    do @(posedge clk); while (req_ready !== 1'b1 && ++n < 9);
    req_valid <= 1'b0;
    #1;
    chk({31'h0, resp_valid}, 32'h1);
  endtask : rq
  // Queue a scanned word, then let it pass the buffer and the image.
  task automatic sc(logic [5:0] s, logic [31:0] w, logic l, bit dr = 1);
    int n;
    n = 0;
    i_slv.push('{1'b0, s, w, l});
    while (dr && slv_idle !== 1'b1 && n++ < 50) @(posedge clk);
    if (dr) repeat (5) @(posedge clk);
    #1;
  endtask : sc
  task automatic ack;
    @(posedge clk);
    int_ack <= 1'b1;
    @(posedge clk);
    int_ack <= 1'b0;
    @(posedge clk);
    #1;
  endtask : ack
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////
  // The watchdog allows over a hundred times the expected run length.
  initial begin
    #200000;
    fails++;
    end_sim();
  end
  initial begin
    {resetn, req_valid, int_ack, out_port, slow} = '0;
    req = '0;
    out_slave = 6'h05;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    #1;
    chk({irq, scan_pause, scan_ready, req_ready}, 32'h3);
    sc(3, 32'ha5, 1);
    chk(irq, 0);
    $display("test reset done");
    foreach (rows[i]) begin
      rq(rows[i].o, rows[i].p, rows[i].s, rows[i].c, rows[i].d);
      chk(resp.err, rows[i].e);
      if (rows[i].o inside {OP_RD_IN, OP_RD_CH_IN, OP_RD_OUT, OP_RD_ALL_IN})
        chk(resp.data, rows[i].r);
    end
    @(posedge clk);
    #1;
    chk(out_word, 32'hffff_ffee);
    $display("test table done");
    slow <= 1'b1;
    rq(OP_SET_CTRL, 0, 0, 0, {31'h0, i_dut.INT_EN_LVL});
    rq(OP_SET_TYPE, 0, 0, 0, 1);
    rq(OP_SET_MASK, 0, 3, 0, 1);
    sc(3, 32'ha7, 0);
    chk(irq, 0);
    sc(3, 32'ha6, 0);
    chk(irq, 1);
    rq(OP_RD_CHG, 0, 3, 0, 0);
    chk(resp.data, 1);
    ack();
    chk(irq, 0);
    rq(OP_SET_TYPE, 0, 0, 0, 2);
    sc(3, 32'ha7, 0);
    chk(irq, 0);
    sc(4, 0, 1);
    chk(irq, 1);
    ack();
    $display("test type one two done");
    rq(OP_SET_TYPE, 0, 0, 0, 3);
    sc(3, 32'ha6, 1);
    chk({irq, scan_pause}, 2'b11);
    repeat (6) sc(4, 0, 0, 0);
    repeat (16) @(posedge clk);
    #1;
    chk({scan_pause, scan_ready}, 2'b10);
    ack();
    sc(4, 0, 0);
    chk({irq, scan_pause, scan_ready}, 3'b001);
    rq(OP_SET_CTRL, 0, 0, 0, {31'h0, ~i_dut.INT_EN_LVL});
    sc(3, 32'ha7, 1);
    chk({irq, scan_pause}, 0);
    $display("test pause and disable done");
    end_sim();
  end
endmodule : tb_dci_top
`default_nettype wire
